// ===== design/pid_loop_consts.vh
/*
 * constants of the pid loop step engine: register byte offsets, control field positions,
 * data format codes, fixed-point layout and timing figures.
 * assumes it is included by bare name from the design files.
 */
`ifndef PID_LOOP_CONSTS_VH
`define PID_LOOP_CONSTS_VH

// register byte offsets
`define REG_CTRL            6'h00
`define REG_STATUS          6'h04
`define REG_SETPOINT        6'h08
`define REG_PROCESS         6'h0c
`define REG_BIAS            6'h10
`define REG_OUTPUT          6'h14
`define REG_SAMPLE_PERIOD   6'h18
`define REG_PROP_GAIN       6'h1c
`define REG_INTEG_COEFF     6'h20
`define REG_DERIV_COEFF     6'h24
`define REG_DEADBAND        6'h28
`define REG_DERIV_TIME      6'h2c
`define REG_DERIV_LIMIT     6'h30
`define REG_FILTERED        6'h34

// control register fields
`define CTRL_TIMER_EN       0
`define CTRL_REVERSE        1
`define CTRL_SQRT           2
`define CTRL_ERR_SQUARE     3
`define CTRL_DEADBAND       4
`define CTRL_GAIN_LIMIT     5
`define CTRL_VELOCITY       6
`define CTRL_MANUAL         7
`define CTRL_FMT_LO         8
`define CTRL_FMT_HI         10
`define CTRL_STEP           16
`define CTRL_RESET          11'h000

// status register fields
`define STAT_BUSY           0
`define STAT_OUT_LOW        1
`define STAT_OUT_HIGH       2

// data formats
`define FMT_U12             3'h0
`define FMT_B12             3'h1
`define FMT_U15             3'h2
`define FMT_B15             3'h3
`define FMT_U16             3'h4

// fixed point: loop values are q16 fractions, coefficients q8.8
`define FRAC_BITS           16
`define COEFF_FRAC          8
`define NORM_MAX            16'hffff
`define ALPHA_ONE           17'h10000

// timing: time registers count microseconds
`define CLK_PERIOD_NS       10
`define MICROSECOND_NS      1000
`define US_CYCLES           (`MICROSECOND_NS / `CLK_PERIOD_NS)

`endif

// ===== design/int_sqrt.v
/*
 * iterative integer square root, two radicand bits per clock.
 * assumes a synchronous-release active-low reset from the instantiating module.
 */
`timescale 1ns/1ps
`default_nettype none

module int_sqrt #(
    parameter WIDTH = 32
) (
    // clock and reset
    input  wire                 clk_i,
    input  wire                 rst_sync_b_i,
    // request
    input  wire                 start_i,
    input  wire [WIDTH-1:0]     radicand_i,
    // answer
    output reg                  done_o,
    output reg  [WIDTH/2-1:0]   root_o
);
    localparam HALF = WIDTH / 2;

    reg  [WIDTH-1:0]    rad_ff;
    reg  [HALF+1:0]     rem_ff;
    reg  [HALF-1:0]     root_ff;
    reg  [HALF:0]       count_ff;
    wire [HALF+3:0]     rem_shift;
    wire [HALF+4:0]     trial;

    // remainder may reach 2*root, so it keeps all HALF+2 bits when shifted
    assign rem_shift = {rem_ff, rad_ff[WIDTH-1:WIDTH-2]};
    assign trial     = {1'b0, rem_shift} - {3'b000, root_ff, 2'b01};

    always @(posedge clk_i or negedge rst_sync_b_i)
    begin
        if (!rst_sync_b_i)
        begin
            rad_ff   <= {WIDTH{1'b0}};
            rem_ff   <= {(HALF+2){1'b0}};
            root_ff  <= {HALF{1'b0}};
            count_ff <= {(HALF+1){1'b0}};
            done_o   <= 1'b0;
            root_o   <= {HALF{1'b0}};
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                rad_ff   <= radicand_i;
                rem_ff   <= {(HALF+2){1'b0}};
                root_ff  <= {HALF{1'b0}};
                count_ff <= {2'b01, {(HALF-1){1'b0}}};
            end
            else if (count_ff != {(HALF+1){1'b0}})
            begin
                rad_ff   <= {rad_ff[WIDTH-3:0], 2'b00};
                count_ff <= count_ff >> 1;
                if (!trial[HALF+4])
                begin
                    rem_ff  <= trial[HALF+1:0];
                    root_ff <= {root_ff[HALF-2:0], 1'b1};
                end
                else
                begin
                    rem_ff  <= rem_shift[HALF+1:0];
                    root_ff <= {root_ff[HALF-2:0], 1'b0};
                end
                if (count_ff == {{HALF{1'b0}}, 1'b1})
                begin
                    done_o <= 1'b1;
                    root_o <= trial[HALF+4] ? {root_ff[HALF-2:0], 1'b0}
                                            : {root_ff[HALF-2:0], 1'b1};
                end
            end
        end
    end
endmodule

`default_nettype wire

// ===== design/pid_loop_special_calc.v
/*
 * one sample step of a pid loop with reverse action, square root of the process value,
 * error squaring, error deadband and derivative gain limiting, behind an avalon-mm slave.
 * assumes software writes setpoint and process words and reads back the control output;
 * control_output_o feeds the analog output side.
 */
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pid_loop_consts.vh"

// Function
// - reverse action negates proportional, integral increment and derivative sign
// - square-root option replaces process value by its root before the loop
// - error squaring: difference times its own absolute value, sign kept
// - deadband forces error to zero when process value is strictly inside band
// - one deadband width serves above and below the setpoint
// - outside the band the full error is used
// - squaring is applied before the deadband test
// - gain limiting filters: y += period/(period+time/limit) times (value - y)
// - position form: bias += integral term; output = p - d*dy + bias
// - derivative coefficient of the plain loop acts on the filtered value
// - formats: 12 and 15 bit unipolar or bipolar, 16 bit unipolar
// - the format applies to setpoint, process value, output and bias
// - normalized bias is clamped to the range zero to one
// - manual mode leaves the output to the operator and skips the computation
module pid_loop_special_calc (
    // clock and reset
    input  wire          clk_i,
    input  wire          rst_b_i,
    // avalon-mm slave
    input  wire [5:0]    address_i,
    input  wire          read_i,
    input  wire          write_i,
    input  wire [31:0]   writedata_i,
    output reg  [31:0]   readdata_o,
    output wire          waitrequest_o,
    // loop output
    output reg  [15:0]   control_output_o,
    output wire          busy_o
);
    localparam S_IDLE = 4'h1;
    localparam S_ROOT = 4'h2;
    localparam S_DIV  = 4'h4;
    localparam S_CALC = 4'h8;

    reg          rst_meta_ff, rst_sync_ff;
    wire         rst_sync_b = rst_sync_ff;
    reg  [3:0]   state_ff;
    reg  [10:0]  ctrl_ff;
    reg  [15:0]  setpoint_value_ff, process_value_ff, bias_term_ff, sample_period_ff;
    reg  [15:0]  proportional_gain_ff, integral_coeff_ff, derivative_coeff_ff;
    reg  [15:0]  deadband_ff, derivative_time_ff, derivative_limit_coeff_ff;
    reg          ack_ff, out_low_ff, out_high_ff;
    reg  [6:0]   prescale_ff;
    reg  [15:0]  tick_ff;
    reg  [4:0]   div_cnt_ff;
    reg  [33:0]  rem_ff;
    reg  [32:0]  den_ff;
    reg  [16:0]  alpha_ff;
    reg  signed [17:0] loop_value_ff, err_prev_ff, filt_prev_ff, filt_prev2_ff;
    reg          root_start_ff;
    wire         root_done;
    wire [15:0]  root_value;

    wire [2:0]   fmt = ctrl_ff[`CTRL_FMT_HI:`CTRL_FMT_LO];
    wire         req = read_i | write_i;
    wire         accept = req & ack_ff;
    wire         wr_go = write_i & accept;
    wire         step_wr = wr_go & (address_i == `REG_CTRL) & writedata_i[`CTRL_STEP];
    wire         us_tick = (prescale_ff == (`US_CYCLES - 1));
    wire         timer_step = ctrl_ff[`CTRL_TIMER_EN] & us_tick & (tick_ff == 16'h0000);
    wire         step = step_wr | timer_step;
    // a step write's own control bits govern the step it starts
    wire [10:0]  step_ctrl = step_wr ? writedata_i[10:0] : ctrl_ff;
    wire [31:0]  per_lim = sample_period_ff * derivative_limit_coeff_ff;

    assign busy_o        = ~state_ff[0];
    assign waitrequest_o = req & ~ack_ff;

    // raw word to q16 fraction; bipolar words become offset binary
    function [15:0] to_norm;
        input [2:0]  f;
        input [15:0] x;
        begin
            case (f)
                `FMT_U12: to_norm = {x[11:0], 4'h0};
                `FMT_B12: to_norm = {~x[11], x[10:0], 4'h0};
                `FMT_U15: to_norm = {x[14:0], 1'b0};
                `FMT_B15: to_norm = {~x[14], x[13:0], 1'b0};
                default:  to_norm = x;
            endcase
        end
    endfunction

    function [15:0] from_norm;
        input [2:0]  f;
        input [15:0] n;
        begin
            case (f)
                `FMT_U12: from_norm = {4'h0, n[15:4]};
                `FMT_B12: from_norm = {{5{~n[15]}}, n[14:4]};
                `FMT_U15: from_norm = {1'b0, n[15:1]};
                `FMT_B15: from_norm = {{2{~n[15]}}, n[14:1]};
                default:  from_norm = n;
            endcase
        end
    endfunction

    // band width scaled like a difference, no offset
    function [15:0] width_norm;
        input [2:0]  f;
        input [15:0] x;
        begin
            case (f)
                `FMT_U12, `FMT_B12: width_norm = {x[11:0], 4'h0};
                `FMT_U15, `FMT_B15: width_norm = {x[14:0], 1'b0};
                default:            width_norm = x;
            endcase
        end
    endfunction

    // q8.8 coefficient times q16 value
    function signed [39:0] coeff_mul;
        input [15:0]        k;
        input signed [19:0] v;
        reg signed [39:0]   prod;
        begin
            prod = $signed({1'b0, k}) * v;
            coeff_mul = prod >>> `COEFF_FRAC;
        end
    endfunction

    function [15:0] clamp_unit;
        input signed [39:0] v;
        begin
            if (v < 0)
                clamp_unit = 16'h0000;
            else if (v > $signed({24'h0, `NORM_MAX}))
                clamp_unit = `NORM_MAX;
            else
                clamp_unit = v[15:0];
        end
    endfunction

    int_sqrt #(.WIDTH(32)) u_root (
        .clk_i        (clk_i),
        .rst_sync_b_i (rst_sync_b),
        .start_i      (root_start_ff),
        .radicand_i   ({to_norm(fmt, process_value_ff), 16'h0000}),
        .done_o       (root_done),
        .root_o       (root_value)
    );

    // loop arithmetic on the values captured for this step
    reg signed [17:0] setpoint_n, diff, diff_neg, err, filt_n;
    reg        [16:0] diff_abs;
    reg signed [35:0] sq_prod, filt_prod;
    reg signed [19:0] err_w, errp_w, fn_w, fp_w, fp2_w;
    reg signed [39:0] p_term, i_term, d_term, bias_sum, out_sum;
    reg        [15:0] bias_new, out_new;
    always @*
    begin
        setpoint_n = $signed({2'b00, to_norm(fmt, setpoint_value_ff)});
        diff       = setpoint_n - loop_value_ff;
        diff_neg   = -diff;
        diff_abs   = diff[17] ? diff_neg[16:0] : diff[16:0];
        sq_prod    = diff * $signed({1'b0, diff_abs});
        err        = diff;
        if (ctrl_ff[`CTRL_ERR_SQUARE])
            err = sq_prod[`FRAC_BITS+17:`FRAC_BITS];
        // band test follows the squaring, full error outside it
        if (ctrl_ff[`CTRL_DEADBAND] &&
            (diff_abs < {1'b0, width_norm(fmt, deadband_ff)}))
            err = 18'sh00000;
        // otherwise err keeps the whole value
        filt_prod = $signed({1'b0, alpha_ff}) * (loop_value_ff - filt_prev_ff);
        if (ctrl_ff[`CTRL_GAIN_LIMIT])
            filt_n = filt_prev_ff + $signed(filt_prod[`FRAC_BITS+17:`FRAC_BITS]);
        else
            filt_n = loop_value_ff;
        err_w  = {{2{err[17]}}, err};
        errp_w = {{2{err_prev_ff[17]}}, err_prev_ff};
        fn_w   = {{2{filt_n[17]}}, filt_n};
        fp_w   = {{2{filt_prev_ff[17]}}, filt_prev_ff};
        fp2_w  = {{2{filt_prev2_ff[17]}}, filt_prev2_ff};
        i_term = coeff_mul(integral_coeff_ff, err_w);
        if (ctrl_ff[`CTRL_VELOCITY])
        begin
            p_term = coeff_mul(proportional_gain_ff, err_w - errp_w);
            d_term = coeff_mul(derivative_coeff_ff, fn_w - fp_w - fp_w + fp2_w);
        end
        else
        begin
            p_term = coeff_mul(proportional_gain_ff, err_w);
            d_term = coeff_mul(derivative_coeff_ff, fn_w - fp_w);
        end
        if (ctrl_ff[`CTRL_REVERSE])
        begin
            p_term = -p_term;
            i_term = -i_term;
            d_term = -d_term;
        end
        bias_sum = $signed({24'h0, to_norm(fmt, bias_term_ff)}) + i_term;
        bias_new = ctrl_ff[`CTRL_VELOCITY] ? to_norm(fmt, bias_term_ff)
                                           : clamp_unit(bias_sum);
        if (ctrl_ff[`CTRL_VELOCITY])
            out_sum = $signed({24'h0, to_norm(fmt, control_output_o)})
                      + p_term + i_term - d_term;
        else
            out_sum = p_term - d_term + $signed({24'h0, bias_new});
        out_new = clamp_unit(out_sum);
    end

    // reset release through two flops
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // step sequencer and history
    always @(posedge clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state_ff      <= S_IDLE;
            root_start_ff <= 1'b0;
            div_cnt_ff    <= 5'h00;
            rem_ff        <= 34'h0;
            den_ff        <= 33'h0;
            alpha_ff      <= 17'h0;
            loop_value_ff <= 18'sh0;
            err_prev_ff   <= 18'sh0;
            filt_prev_ff  <= 18'sh0;
            filt_prev2_ff <= 18'sh0;
        end
        else
        begin
            root_start_ff <= 1'b0;
            case (state_ff)
                S_IDLE:
                    if (step && !step_ctrl[`CTRL_MANUAL])
                    begin
                        root_start_ff <= step_ctrl[`CTRL_SQRT];
                        state_ff      <= S_ROOT;
                    end
                S_ROOT:
                    if (!ctrl_ff[`CTRL_SQRT] || root_done)
                    begin
                        loop_value_ff <= ctrl_ff[`CTRL_SQRT] ?
                                         $signed({2'b00, root_value}) :
                                         $signed({2'b00, to_norm(fmt, process_value_ff)});
                        rem_ff   <= {2'b00, per_lim};
                        den_ff   <= {1'b0, per_lim} + {9'h000, derivative_time_ff, 8'h00};
                        alpha_ff <= 17'h0;
                        div_cnt_ff <= 5'h10;
                        state_ff   <= S_DIV;
                    end
                S_DIV:
                    // alpha = period*limit / (period*limit + 256*time), q16
                    if (div_cnt_ff != 5'h00)
                    begin
                        div_cnt_ff <= div_cnt_ff - 5'h01;
                        if ({rem_ff[32:0], 1'b0} >= {1'b0, den_ff})
                        begin
                            rem_ff   <= {rem_ff[32:0], 1'b0} - {1'b0, den_ff};
                            alpha_ff <= {alpha_ff[15:0], 1'b1};
                        end
                        else
                        begin
                            rem_ff   <= {rem_ff[32:0], 1'b0};
                            alpha_ff <= {alpha_ff[15:0], 1'b0};
                        end
                    end
                    else
                    begin
                        if (derivative_time_ff == 16'h0000)
                            alpha_ff <= `ALPHA_ONE;
                        state_ff <= S_CALC;
                    end
                S_CALC:
                begin
                    err_prev_ff   <= err;
                    filt_prev_ff  <= filt_n;
                    filt_prev2_ff <= filt_prev_ff;
                    state_ff      <= S_IDLE;
                end
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end

    // register file, bus handshake and sample timer
    always @(posedge clk_i or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ack_ff                    <= 1'b0;
            readdata_o                <= 32'h0;
            ctrl_ff                   <= `CTRL_RESET;
            setpoint_value_ff         <= 16'h0;
            process_value_ff          <= 16'h0;
            bias_term_ff              <= 16'h0;
            control_output_o          <= 16'h0;
            sample_period_ff          <= 16'h0;
            proportional_gain_ff      <= 16'h0;
            integral_coeff_ff         <= 16'h0;
            derivative_coeff_ff       <= 16'h0;
            deadband_ff               <= 16'h0;
            derivative_time_ff        <= 16'h0;
            derivative_limit_coeff_ff <= 16'h0;
            out_low_ff                <= 1'b0;
            out_high_ff               <= 1'b0;
            prescale_ff               <= 7'h0;
            tick_ff                   <= 16'h0;
        end
        else
        begin
            // one wait state; writes also wait out a running step
            ack_ff <= req & ~ack_ff & ~(write_i & busy_o);
            if (req && !ack_ff)
            begin
                case (address_i)
                    `REG_CTRL:          readdata_o <= {21'h0, ctrl_ff};
                    `REG_STATUS:        readdata_o <= {29'h0, out_high_ff, out_low_ff, busy_o};
                    `REG_SETPOINT:      readdata_o <= {16'h0, setpoint_value_ff};
                    `REG_PROCESS:       readdata_o <= {16'h0, process_value_ff};
                    `REG_BIAS:          readdata_o <= {16'h0, bias_term_ff};
                    `REG_OUTPUT:        readdata_o <= {16'h0, control_output_o};
                    `REG_SAMPLE_PERIOD: readdata_o <= {16'h0, sample_period_ff};
                    `REG_PROP_GAIN:     readdata_o <= {16'h0, proportional_gain_ff};
                    `REG_INTEG_COEFF:   readdata_o <= {16'h0, integral_coeff_ff};
                    `REG_DERIV_COEFF:   readdata_o <= {16'h0, derivative_coeff_ff};
                    `REG_DEADBAND:      readdata_o <= {16'h0, deadband_ff};
                    `REG_DERIV_TIME:    readdata_o <= {16'h0, derivative_time_ff};
                    `REG_DERIV_LIMIT:   readdata_o <= {16'h0, derivative_limit_coeff_ff};
                    `REG_FILTERED:      readdata_o <= {14'h0, filt_prev_ff};
                    default:            readdata_o <= 32'h0;
                endcase
            end
            if (wr_go)
            begin
                case (address_i)
                    `REG_CTRL:          ctrl_ff <= writedata_i[10:0];
                    `REG_SETPOINT:      setpoint_value_ff <= writedata_i[15:0];
                    `REG_PROCESS:       process_value_ff <= writedata_i[15:0];
                    `REG_BIAS:          bias_term_ff <= writedata_i[15:0];
                    `REG_OUTPUT:        control_output_o <= writedata_i[15:0];
                    `REG_SAMPLE_PERIOD: sample_period_ff <= writedata_i[15:0];
                    `REG_PROP_GAIN:     proportional_gain_ff <= writedata_i[15:0];
                    `REG_INTEG_COEFF:   integral_coeff_ff <= writedata_i[15:0];
                    `REG_DERIV_COEFF:   derivative_coeff_ff <= writedata_i[15:0];
                    `REG_DEADBAND:      deadband_ff <= writedata_i[15:0];
                    `REG_DERIV_TIME:    derivative_time_ff <= writedata_i[15:0];
                    `REG_DERIV_LIMIT:   derivative_limit_coeff_ff <= writedata_i[15:0];
                    default:            ;
                endcase
            end
            if (state_ff == S_CALC)
            begin
                bias_term_ff     <= from_norm(fmt, bias_new);
                control_output_o <= from_norm(fmt, out_new);
                out_low_ff       <= (out_sum < 0);
                out_high_ff      <= (out_sum > $signed({24'h0, `NORM_MAX}));
            end
            prescale_ff <= us_tick ? 7'h0 : prescale_ff + 7'h1;
            if (!ctrl_ff[`CTRL_TIMER_EN])
                tick_ff <= 16'h0;
            else if (us_tick)
                tick_ff <= (tick_ff == 16'h0000) ? sample_period_ff - 16'h1 : tick_ff - 16'h1;
        end
    end
endmodule

`default_nettype wire

// ===== dv/pid_loop_chk.sv
/* port assertions for the pid step engine.
   assumes one wait state on reads and busy_o framing every loop step. */
`timescale 1ns/1ps
`default_nettype none
module pid_loop_chk (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic [5:0]  address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic [15:0] control_output_o,
    input wire logic        busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire st_w = write_i && !waitrequest_o && address_i == 6'h00 && writedata_i[16];
    wire rd_w = read_i && !waitrequest_o;
    a_read_wait: assert property ($rose(read_i) |-> waitrequest_o ##1 !waitrequest_o)
        else $error("read wait state wrong");
    a_out_cause: assert property ($changed(control_output_o) |->
        $fell(busy_o) || $past(write_i && !waitrequest_o && address_i == 6'h14))
        else $error("output changed without cause");
    a_step_start: assert property (st_w && !writedata_i[7] && !busy_o |=> busy_o)
        else $error("step did not start");
    a_manual_idle: assert property (st_w && writedata_i[7] && !busy_o |=> !busy_o [*2])
        else $error("step ran in manual mode");
    a_busy_min: assert property ($rose(busy_o) |-> busy_o [*8])
        else $error("step ended too soon");
    a_busy_bound: assert property ($rose(busy_o) |-> ##[1:80] !busy_o)
        else $error("step never ended");
    a_unmapped_zero: assert property (rd_w && address_i > 6'h34 |-> readdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_out_mirror: assert property (rd_w && address_i == 6'h14 |->
        readdata_o == {16'h0000, $past(control_output_o)})
        else $error("output word differs from port");
    cover property (st_w && !writedata_i[7]);
    cover property (st_w && writedata_i[7]);
    cover property (rd_w && address_i > 6'h34);
endmodule
bind pid_loop_special_calc pid_loop_chk u_pid_loop_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .control_output_o(control_output_o), .busy_o(busy_o));
`default_nettype wire

// ===== dv/analog_io_model.sv
/* analog output side: latches each control output that a loop step sends.
   assumes busy_o falls at the edge that writes the output. */
`timescale 1ns/1ps
`default_nettype none
module analog_io_model (
    input  wire logic        clk_i,
    input  wire logic        busy_i,
    input  wire logic [15:0] level_i,
    output var  logic [15:0] sent_o
);
    logic busy_q = 1'b0;
    initial sent_o = 16'h0000;
    always @(posedge clk_i)
    begin
        busy_q <= busy_i;
        if (busy_q && !busy_i) sent_o <= level_i;
    end
endmodule
`default_nettype wire

// ===== dv/pid_loop_special_calc_test.sv
/* self-checking bench: avalon master tasks, integer reference model, analog model.
   assumes the design and the dv files above are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
$display("MISMATCH %s expected %h seen %h", n, e, a); end end
module pid_loop_special_calc_test;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, read_i = 1'b0, write_i = 1'b0, w;
    logic [5:0]  address_i = 6'h00;
    logic [31:0] writedata_i = 32'h0, rd;
    logic [15:0] exp_o = 16'h0, exp_b;
    wire  [31:0] readdata_o;
    wire  [15:0] control_output_o, sent;
    wire         waitrequest_o, busy_o;
    int          fail_count = 0, total_checks = 0, last_pv = 0, s, p;
    always #5 clk_i = ~clk_i;
    pid_loop_special_calc u_pid_loop_special_calc (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .control_output_o(control_output_o), .busy_o(busy_o));
    analog_io_model u_analog_io_model (.clk_i(clk_i), .busy_i(busy_o),
        .level_i(control_output_o), .sent_o(sent));
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= d;
        write_i <= wr;
        read_i <= !wr;
        w = 1'b1;
        for (n = 0; n < 200 && w !== 1'b0; n++)
        begin
            @(posedge clk_i);
            w = waitrequest_o;
        end
        rd = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        if (w !== 1'b0) begin fail_count++; close_out(); end
    endtask
    task automatic step(input logic [31:0] c);
        int n;
        bus(1'b1, 6'h00, c | 32'h10000);
        for (n = 0; n < 300 && (n == 0 || busy_o !== 1'b0); n++)
            @(negedge clk_i);
        if (n >= 300) begin fail_count++; close_out(); end
    endtask
    function automatic int clip(int v);
        return v < 0 ? 0 : (v > 65535 ? 65535 : v);
    endfunction
    task automatic run(input logic [31:0] c, input int sp, pv, b, kp, ki, kr, db);
        int e, o;
        bus(1'b1, 6'h08, sp);
        bus(1'b1, 6'h0c, pv);
        bus(1'b1, 6'h10, b);
        bus(1'b1, 6'h1c, kp);
        bus(1'b1, 6'h20, ki);
        bus(1'b1, 6'h24, kr);
        bus(1'b1, 6'h28, db);
        step(c);
        if (c[2]) pv = int'($floor($sqrt(pv * 65536.0)));
        e = sp - pv;
        if (c[3]) e = e * (e < 0 ? -e : e) / 65536;
        if (c[4] && sp - pv < db && pv - sp < db) e = 0;
        o = kr * (pv - last_pv) / 256;
        last_pv = pv;
        if (c[1]) begin e = -e; o = -o; end
        if (c[6]) o = clip(exp_o + ki * e / 256 - o);
        else begin b = clip(b + ki * e / 256); o = clip(kp * e / 256 - o + b); end
        exp_o = o;
        exp_b = b;
        bus(1'b0, 6'h14, 32'h0);
        `CHK("output", exp_o, rd[15:0])
        `CHK("sent", exp_o, sent)
        bus(1'b0, 6'h10, 32'h0);
        `CHK("bias", exp_b, rd[15:0])
        $display("step %h done", c);
    endtask
    initial
    begin
        s = $urandom(32'h0636);
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        bus(1'b0, 6'h3c, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        bus(1'b1, 6'h2c, 32'h0);
        bus(1'b1, 6'h30, 32'h100);
        for (s = 0; s < 5; s++)
            run(s << 8, 32'h100, 32'h80, 32'h40, 256, 0, 0, 0);
        for (s = 0; s < 4; s++)
        begin
            p = $urandom_range(16'hf000, 16'h8000);
            run(32'h400, p, p - $urandom_range(16'h3000, 0), $urandom_range(16'h2000, 0),
                256, 256, 0, 0);
        end
        run(32'h402, 32'h8000, 32'h7000, 32'h4000, 256, 256, 0, 0);
        run(32'h404, 32'h8000, 32'h4000, 32'h3000, 256, 0, 0, 0);
        run(32'h408, 32'h7000, 32'h8000, 32'h4000, 256, 0, 0, 0);
        run(32'h410, 32'h8000, 32'h7000, 32'h4000, 256, 0, 0, 32'h1001);
        run(32'h410, 32'h7000, 32'h8000, 32'h4000, 256, 0, 0, 32'h1001);
        run(32'h410, 32'h8000, 32'h7000, 32'h4000, 256, 0, 0, 32'h1000);
        run(32'h418, 32'h8000, 32'h7000, 32'h4000, 256, 0, 0, 32'h1001);
        run(32'h420, 32'h8000, 32'h4000, 32'h6000, 0, 0, 0, 0);
        run(32'h420, 32'h8000, 32'h5000, 32'h6000, 0, 0, 256, 0);
        bus(1'b0, 6'h34, 32'h0);
        `CHK("filtered", 18'h05000, rd[17:0])
        bus(1'b1, 6'h18, 32'h100);
        bus(1'b1, 6'h2c, 32'h200);
        bus(1'b1, 6'h30, 32'h200);
        run(32'h420, 32'h8000, 32'h6000, 32'h6000, 0, 0, 0, 0);
        bus(1'b0, 6'h34, 32'h0);
        `CHK("filtered half", 18'h05800, rd[17:0])
        run(32'h460, 32'h8000, 32'h7000, 32'h4000, 0, 256, 0, 0);
        run(32'h400, 32'h1000, 32'h9000, 32'h1000, 0, 256, 0, 0);
        bus(1'b1, 6'h00, 32'h480);
        bus(1'b1, 6'h14, 32'h1234);
        step(32'h480);
        bus(1'b0, 6'h14, 32'h0);
        `CHK("manual", 32'h1234, rd)
        close_out();
    end
endmodule
`default_nettype wire
